// ### src/dev_cfg_pkg.sv
/*
  Constants for the hub device configuration register: offset, bit positions, reset values and modes.
  Assumes a single 125 MHz core clock and an asynchronous active-low power-on reset.
*/
// Summary of operation
// - Bit 7 unlocks writes to the manufacturer and product strings, their lengths and the language ID, and resets to 0.
// - Bit 6 unlocks writes to the serial number string and its length, and resets to 0.
// - With bit 5 clear, U1 and U2 link low-power states are allowed on every port as normal.
// - With bit 5 set, U1 and U2 entry is neither started nor accepted unless a force-accept link message was seen.
// - After a force-accept link message is sent or received, U1 and U2 follow normal rules until power-on reset or upstream disconnect.
// - In EEPROM mode bits 5, 3 and 2 are loaded from the EEPROM contents.
// - In SMBus mode a host write replaces bits 5, 3 and 2.
// - Bit 4 always reads 1.
// - Bit 3 takes the power-group strap level when reset is released.
// - With reporting on and bit 3 clear, each port power is switched by its own control pin.
// - With reporting on and bit 3 set, all ports are switched together by the first port's control pin.
// - Bit 2 takes the power-reporting strap level when reset is released.
// - Port power switching status is reported when bit 2 is 0 and not when it is 1.
// - Bit 0 always reads 0.
// - The register sits at offset 5h of the configuration space.
package dev_cfg_pkg;
  localparam logic [7:0] CFG_OFFSET = 8'h05;
  localparam int STR_UNLOCK_BIT = 7;
  localparam int SER_UNLOCK_BIT = 6;
  localparam int LPM_BLOCK_BIT = 5;
  localparam int RSVD_ONE_BIT = 4;
  localparam int GROUP_BIT = 3;
  localparam int REPORT_OFF_BIT = 2;
  localparam int RSVD_RW_BIT = 1;
  localparam int RSVD_ZERO_BIT = 0;
  localparam logic STR_UNLOCK_RST = 1'h0;
  localparam logic SER_UNLOCK_RST = 1'h0;
  localparam logic LPM_BLOCK_RST = 1'h0;
  localparam logic RSVD_ONE_VAL = 1'h1;
  localparam logic RSVD_RW_RST = 1'h0;
  localparam logic RSVD_ZERO_VAL = 1'h0;
  // Bits that a load or a host write may change.
  localparam logic [7:0] WRITE_MASK = 8'hEE;
  typedef enum logic [1:0] {MODE_PINS, MODE_EEPROM, MODE_SMBUS} cfg_mode_t;
endpackage : dev_cfg_pkg

// ### src/hub_device_config_register.sv
/*
  Device configuration register of a four-port hub at offset 5h, with strap capture,
  EEPROM load and SMBus write paths, and the decoded controls that steer the hub.
  Assumes the configuration source presents one byte strobe per cycle at most, and
  that the link layer pulses forceAcceptSeen when a force-accept link message passes.
*/
`timescale 1ns/1ps
module hub_device_config_register #(
  parameter int NUM_PORTS = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire dev_cfg_pkg::cfg_mode_t cfgMode,
  input wire logic powerGroupStrapPin,
  input wire logic powerReportStrapPin,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  input wire logic forceAcceptSeen,
  input wire logic upstreamDisconnect,
  input wire logic [NUM_PORTS-1:0] portPowerRequest,
  output logic [NUM_PORTS-1:0] portPowerControlPins,
  output logic stringWriteUnlock,
  output logic serialWriteUnlock,
  output logic linkLowPowerBlock,
  output logic lowPowerAllowed,
  output logic powerStatusReportOn,
  output logic powerGroupMode
);
  typedef struct packed {
    logic strUnlock;
    logic serUnlock;
    logic lpmBlock;
    logic group;
    logic reportOff;
    logic rsvdRw;
    logic [NUM_PORTS-1:0] pwrCtl;
    logic strapSeen;
  } cfg_state_t;
  cfg_state_t state_reg;
  cfg_state_t state_next;

  logic strapValid;
  logic strapGroup;
  logic strapReportOff;
  logic strapSeen;
  logic forceAcceptLatched;
  logic hitCfg;
  logic loadPath;

  function automatic logic [7:0] pack_cfg(input cfg_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[dev_cfg_pkg::STR_UNLOCK_BIT] = s.strUnlock;
    v[dev_cfg_pkg::SER_UNLOCK_BIT] = s.serUnlock;
    v[dev_cfg_pkg::LPM_BLOCK_BIT] = s.lpmBlock;
    v[dev_cfg_pkg::RSVD_ONE_BIT] = dev_cfg_pkg::RSVD_ONE_VAL;
    v[dev_cfg_pkg::GROUP_BIT] = s.group;
    v[dev_cfg_pkg::REPORT_OFF_BIT] = s.reportOff;
    v[dev_cfg_pkg::RSVD_RW_BIT] = s.rsvdRw;
    v[dev_cfg_pkg::RSVD_ZERO_BIT] = dev_cfg_pkg::RSVD_ZERO_VAL;
    return v;
  endfunction : pack_cfg

  strap_capture u_strap (
    .clk(clk),
    .arst_n(arst_n),
    .powerGroupStrapPin(powerGroupStrapPin),
    .powerReportStrapPin(powerReportStrapPin),
    .strapValid(strapValid),
    .strapGroup(strapGroup),
    .strapReportOff(strapReportOff)
  );

  lpm_gate u_lpm (
    .clk(clk),
    .arst_n(arst_n),
    .linkLowPowerBlock(state_reg.lpmBlock),
    .forceAcceptSeen(forceAcceptSeen),
    .upstreamDisconnect(upstreamDisconnect),
    .lowPowerAllowed(lowPowerAllowed),
    .forceAcceptLatched(forceAcceptLatched)
  );

  assign hitCfg = regWrite && (regAddr == dev_cfg_pkg::CFG_OFFSET);
  assign loadPath = (cfgMode == dev_cfg_pkg::MODE_EEPROM) || (cfgMode == dev_cfg_pkg::MODE_SMBUS);

  always_comb begin
    state_next = state_reg;
    // The strap edge is remembered so that the capture happens only once per reset.
    state_next.strapSeen = strapValid;
    if (strapValid && !state_reg.strapSeen) begin
      state_next.group = strapGroup;
      state_next.reportOff = strapReportOff;
    end else if (hitCfg && loadPath) begin
      state_next.lpmBlock = regWriteData[dev_cfg_pkg::LPM_BLOCK_BIT];
      state_next.group = regWriteData[dev_cfg_pkg::GROUP_BIT];
      state_next.reportOff = regWriteData[dev_cfg_pkg::REPORT_OFF_BIT];
      state_next.strUnlock = regWriteData[dev_cfg_pkg::STR_UNLOCK_BIT];
      state_next.serUnlock = regWriteData[dev_cfg_pkg::SER_UNLOCK_BIT];
      state_next.rsvdRw = regWriteData[dev_cfg_pkg::RSVD_RW_BIT];
      // bits 4 and 0 have no storage, so writes to them are dropped.
    end
    if (!state_reg.reportOff && state_reg.group) begin
      state_next.pwrCtl = '0;
      state_next.pwrCtl[0] = |portPowerRequest;
    end else begin
      state_next.pwrCtl = portPowerRequest;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign regReadData = pack_cfg(state_reg);
  assign portPowerControlPins = state_reg.pwrCtl;
  assign stringWriteUnlock = state_reg.strUnlock;
  assign serialWriteUnlock = state_reg.serUnlock;
  assign linkLowPowerBlock = state_reg.lpmBlock;
  assign powerStatusReportOn = !state_reg.reportOff;
  assign powerGroupMode = state_reg.group;
  assign strapSeen = state_reg.strapSeen;

  a_unlock_str_write: assert property (@(posedge clk) disable iff (!arst_n)
    hitCfg && loadPath && strapSeen |=> stringWriteUnlock == $past(regWriteData[7]))
    else $error("String unlock did not follow write.");
  a_unlock_ser_write: assert property (@(posedge clk) disable iff (!arst_n)
    hitCfg && loadPath && strapSeen |=> serialWriteUnlock == $past(regWriteData[6]))
    else $error("Serial unlock did not follow write.");
  a_host_write_fields: assert property (@(posedge clk) disable iff (!arst_n)
    hitCfg && loadPath && strapSeen |=> regReadData[5:2] == {$past(regWriteData[5]), 1'b1, $past(regWriteData[3:2])})
    else $error("Configurable fields not replaced by write.");
  a_pins_mode_ignores: assert property (@(posedge clk) disable iff (!arst_n)
    regWrite && cfgMode == dev_cfg_pkg::MODE_PINS && strapSeen |=> $stable(regReadData))
    else $error("Register changed without a load path.");
  a_rsvd_one_bit: assert property (@(posedge clk) disable iff (!arst_n)
    regReadData[4] == 1'b1)
    else $error("Reserved bit 4 not one.");
  a_rsvd_zero_bit: assert property (@(posedge clk) disable iff (!arst_n)
    regReadData[0] == 1'b0)
    else $error("Reserved bit 0 not zero.");
  a_strap_capture_once: assert property (@(posedge clk) disable iff (!arst_n)
    strapValid && !strapSeen |=> powerGroupMode == $past(strapGroup) && regReadData[2] == $past(strapReportOff))
    else $error("Strap levels not captured.");
  a_ganged_power_pin: assert property (@(posedge clk) disable iff (!arst_n)
    powerStatusReportOn && powerGroupMode |=> portPowerControlPins[NUM_PORTS-1:1] == '0)
    else $error("Grouped mode drove more than the first pin.");
  a_individual_power: assert property (@(posedge clk) disable iff (!arst_n)
    !powerGroupMode |=> portPowerControlPins == $past(portPowerRequest))
    else $error("Individual power control did not follow request.");

  a_other_addr_ignored: assert property (@(posedge clk) disable iff (!arst_n)
    regWrite && regAddr != dev_cfg_pkg::CFG_OFFSET && strapSeen |=> $stable(regReadData))
    else $error("Write to another offset changed the register.");
  a_report_strap_once: assert property (@(posedge clk) disable iff (!arst_n)
    strapValid && !strapSeen |=> powerStatusReportOn == !$past(strapReportOff))
    else $error("Reporting strap not captured.");
  a_ganged_pin_or: assert property (@(posedge clk) disable iff (!arst_n)
    powerStatusReportOn && powerGroupMode |=> portPowerControlPins[0] == |$past(portPowerRequest))
    else $error("Grouped first pin did not follow the requests.");
  a_block_write_denies: assert property (@(posedge clk) disable iff (!arst_n)
    hitCfg && loadPath && strapSeen && regWriteData[dev_cfg_pkg::LPM_BLOCK_BIT] && !forceAcceptLatched
      && !forceAcceptSeen |=> !lowPowerAllowed)
    else $error("Low power allowed after the block bit was written.");
  a_clear_write_allows: assert property (@(posedge clk) disable iff (!arst_n)
    hitCfg && loadPath && strapSeen && !regWriteData[dev_cfg_pkg::LPM_BLOCK_BIT] |=> lowPowerAllowed)
    else $error("Low power denied after the block bit was cleared.");

  c_host_write: cover property (@(posedge clk) disable iff (!arst_n) hitCfg && cfgMode == dev_cfg_pkg::MODE_SMBUS);
  c_eeprom_load: cover property (@(posedge clk) disable iff (!arst_n) hitCfg && cfgMode == dev_cfg_pkg::MODE_EEPROM);
  c_forced_lpm: cover property (@(posedge clk) disable iff (!arst_n) linkLowPowerBlock && forceAcceptLatched);
  c_grouped_power: cover property (@(posedge clk) disable iff (!arst_n) powerStatusReportOn && powerGroupMode);
endmodule : hub_device_config_register

// ### src/lpm_gate.sv
/*
  Decides whether U1/U2 entry is allowed, holding the force-accept latch.
  Assumes forceAcceptSeen and upstreamDisconnect are one-cycle pulses from the link layer.
*/
`timescale 1ns/1ps
module lpm_gate (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic linkLowPowerBlock,
  input wire logic forceAcceptSeen,
  input wire logic upstreamDisconnect,
  output logic lowPowerAllowed,
  output logic forceAcceptLatched
);
  typedef struct packed {
    logic forced;
  } lpm_state_t;
  lpm_state_t state_reg;
  lpm_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (upstreamDisconnect) begin
      state_next.forced = 1'b0;
    end
    // A message in the same cycle as a disconnect wins, so it is never lost.
    if (forceAcceptSeen) begin
      state_next.forced = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign lowPowerAllowed = !linkLowPowerBlock || state_reg.forced;
  assign forceAcceptLatched = state_reg.forced;

  a_force_latch_holds: assert property (@(posedge clk) disable iff (!arst_n)
    state_reg.forced && !upstreamDisconnect |=> lowPowerAllowed)
    else $error("Force-accept latch dropped without disconnect.");
  a_block_denies_lpm: assert property (@(posedge clk) disable iff (!arst_n)
    linkLowPowerBlock && !state_reg.forced |-> !lowPowerAllowed)
    else $error("Low power allowed while blocked.");
  a_clear_allows_lpm: assert property (@(posedge clk) disable iff (!arst_n)
    !linkLowPowerBlock |-> lowPowerAllowed)
    else $error("Low power denied while block bit clear.");
  a_force_sets_latch: assert property (@(posedge clk) disable iff (!arst_n)
    forceAcceptSeen |=> forceAcceptLatched)
    else $error("Force-accept message not latched.");
  a_disconnect_clears: assert property (@(posedge clk) disable iff (!arst_n)
    upstreamDisconnect && !forceAcceptSeen |=> !forceAcceptLatched)
    else $error("Force-accept latch kept after disconnect.");
endmodule : lpm_gate

// ### src/strap_capture.sv
/*
  Catches the two strap levels once, on the first clock edge after reset release.
  Assumes the strap pins are stable around reset release and synchronous to clk.
*/
`timescale 1ns/1ps
module strap_capture (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic powerGroupStrapPin,
  input wire logic powerReportStrapPin,
  output logic strapValid,
  output logic strapGroup,
  output logic strapReportOff
);
  typedef struct packed {
    logic done;
    logic group;
    logic reportOff;
  } strap_state_t;
  strap_state_t state_reg;
  strap_state_t state_next;

  // Reset loads constants only; the pin levels are taken by the first clocked edge after release.
  always_comb begin
    state_next = state_reg;
    if (!state_reg.done) begin
      state_next.done = 1'b1;
      state_next.group = powerGroupStrapPin;
      state_next.reportOff = powerReportStrapPin;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign strapValid = state_reg.done;
  assign strapGroup = state_reg.group;
  assign strapReportOff = state_reg.reportOff;
endmodule : strap_capture

// ### tb/cfg_source_model.sv
/*
  Configuration source model: an SMBus host or EEPROM loader that writes single bytes.
  Assumes the bench calls write_byte and idle just after a rising edge of clk.
*/
`timescale 1ns/1ps
module cfg_source_model (
  input wire logic clk,
  output logic regWrite,
  output logic [7:0] regAddr,
  output logic [7:0] regWriteData
);
  initial begin
    regWrite = 1'h0;
    regAddr = 8'h00;
    regWriteData = 8'h00;
  end
  // byte write, bit 1 default
  // Bit 1 goes out at its default, so images never disturb the reserved bit.
  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    regWrite <= 1'h1;
    regAddr <= addr;
    regWriteData <= data & 8'hFD;
  endtask : write_byte
  // Released lines show a changing pattern, so a stale value cannot pass for a held one.
  task automatic idle();
    @(posedge clk);
    regWrite <= 1'h0;
    regAddr <= ~regAddr;
    regWriteData <= ~regWriteData;
  endtask : idle
endmodule : cfg_source_model

// ### tb/hub_device_config_register_tb.sv
/*
  Self-checking bench for the hub device configuration register.
  Assumes results show one cycle after each taken edge and straps hold from the second edge.
*/
`timescale 1ns/1ps
module hub_device_config_register_tb;
  typedef struct {int kind; logic [7:0] exp; int due;} note_t;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  dev_cfg_pkg::cfg_mode_t cfgMode = dev_cfg_pkg::MODE_PINS;
  logic groupStrap = 1'h0;
  logic reportStrap = 1'h0;
  logic forceAcceptSeen = 1'h0;
  logic upstreamDisconnect = 1'h0;
  logic [3:0] portPowerRequest = 4'h0;
  logic regWrite;
  logic [7:0] regAddr, regWriteData, regReadData;
  logic [3:0] portPowerControlPins;
  logic stringWriteUnlock, serialWriteUnlock, linkLowPowerBlock, lowPowerAllowed, powerStatusReportOn, powerGroupMode;
  logic [7:0] outFlags;
  note_t notes[$];
  note_t cur;
  int errors = 0;
  int checksDone = 0;
  int cyc = 0;
  logic [7:0] model = 8'h10;
  logic latch = 1'h0;

  always #4 clk = ~clk;

  assign outFlags = {2'h0, stringWriteUnlock, serialWriteUnlock, linkLowPowerBlock, lowPowerAllowed,
    powerStatusReportOn, powerGroupMode};

  cfg_source_model src (.clk(clk), .regWrite(regWrite), .regAddr(regAddr), .regWriteData(regWriteData));

  hub_device_config_register #(.NUM_PORTS(4)) DUT (
    .clk(clk), .arst_n(arst_n), .cfgMode(cfgMode), .powerGroupStrapPin(groupStrap),
    .powerReportStrapPin(reportStrap), .regWrite(regWrite), .regAddr(regAddr), .regWriteData(regWriteData),
    .regReadData(regReadData), .forceAcceptSeen(forceAcceptSeen), .upstreamDisconnect(upstreamDisconnect),
    .portPowerRequest(portPowerRequest), .portPowerControlPins(portPowerControlPins),
    .stringWriteUnlock(stringWriteUnlock), .serialWriteUnlock(serialWriteUnlock),
    .linkLowPowerBlock(linkLowPowerBlock), .lowPowerAllowed(lowPowerAllowed),
    .powerStatusReportOn(powerStatusReportOn), .powerGroupMode(powerGroupMode));

  function automatic logic [7:0] flags(input logic [7:0] r, input logic l);
    return {2'h0, r[7], r[6], r[5], !r[5] || l, !r[2], r[3]};
  endfunction : flags

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic expect_at(input int kind, input logic [7:0] exp, input int lag);
    notes.push_back('{kind, exp, cyc + lag});
  endtask : expect_at

  task automatic expect_state(input int lag);
    expect_at(0, model, lag);
    expect_at(2, flags(model, latch), lag);
  endtask : expect_state

  // Results are taken on the falling edge, well after the rising-edge updates settle.
  always @(negedge clk) begin
    cyc++;
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      cur = notes.pop_front();
      case (cur.kind)
        0: check8("regReadData", cur.exp, regReadData);
        1: check8("portPowerControlPins", cur.exp, {4'h0, portPowerControlPins});
        default: check8("flags", cur.exp, outFlags);
      endcase
    end
  end

  task automatic do_reset(input logic g, input logic r);
    arst_n <= 1'h0;
    groupStrap <= g;
    reportStrap <= r;
    latch = 1'h0;
    model = {4'h1, g, r, 2'h0};
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    expect_state(3);
    repeat (2) @(posedge clk);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    src.write_byte(a, d);
    if (a == dev_cfg_pkg::CFG_OFFSET && cfgMode != dev_cfg_pkg::MODE_PINS)
      model = (d & dev_cfg_pkg::WRITE_MASK & 8'hFD) | 8'h10;
    expect_state(2);
  endtask : wr

  task automatic pulse_link(input logic f, input logic d);
    @(posedge clk);
    forceAcceptSeen <= f;
    upstreamDisconnect <= d;
    if (f)
      latch = 1'h1;
    else if (d)
      latch = 1'h0;
    expect_state(2);
    @(posedge clk);
    forceAcceptSeen <= 1'h0;
    upstreamDisconnect <= 1'h0;
  endtask : pulse_link

  task automatic power_req(input logic [3:0] req);
    logic [3:0] e;
    @(posedge clk);
    portPowerRequest <= req;
    e = (!model[2] && model[3]) ? {3'h0, |req} : req;
    expect_at(1, {4'h0, e}, 2);
  endtask : power_req

  task automatic report_and_stop();
    if (errors == 0 && checksDone > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial begin
    #(8 * 2000);
    errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h64b9ef36));
    do_reset(1'h1, 1'h0);
    wr(8'h05, 8'hFF);
    src.idle();
    for (int i = 0; i < 40; i++) begin
      cfgMode <= i[1] ? dev_cfg_pkg::MODE_EEPROM : dev_cfg_pkg::MODE_SMBUS;
      wr(i[0] ? 8'h05 : 8'($urandom), 8'($urandom));
    end
    wr(8'h05, 8'hE0);
    src.idle();
    pulse_link(1'h1, 1'h0);
    wr(8'h05, 8'h24);
    src.idle();
    pulse_link(1'h0, 1'h1);
    pulse_link(1'h1, 1'h1);
    wr(8'h05, 8'h00);
    src.idle();
    pulse_link(1'h0, 1'h1);
    for (int k = 0; k < 3; k++) begin
      wr(8'h05, k == 0 ? 8'h08 : (k == 1 ? 8'h00 : 8'h0C));
      src.idle();
      repeat (6) power_req(4'($urandom));
    end
    repeat (3) @(posedge clk);
    do_reset(1'h0, 1'h1);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : hub_device_config_register_tb
